// ===== rtcc_top.sv
// real-time clock, calendar, alarm and stopwatch behind an apb slave
// assumes oscillator_reference_clock is synchronous to pclk and far slower than it
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "rtcc_map.svh"

// Operation
// - crystal_select picks prescaler and tick rate
// - crystal_select clears on reset, first write only
// - each flag with its enable requests interrupt
// - alarm flag sets on hour and minute match
// - alarm clears: status read, then alarm hour read
// - stopwatch flag per tick, cleared via stopwatch read
// - counter flags per increment, cleared via own read
// - half and quarter second flags, stopwatch read clears
// - alarm registers take any value, invalid never matches
// - counter reads harmless, valid writes load counter
// - seconds wrap after 59, bad writes ignored
// - minutes wrap after 59, bad writes ignored
// - hours wrap after 23, bad writes ignored
// - day wraps to one after month end
// - month wraps to one after 12
// - year is signed offset, -99 to +99 only
// - weekday wraps after 6, bad writes ignored
// - stopwatch count read-only, cleared by reset or clear
// - stopwatch step is 10 ms, wraps after 99
// - stopwatch holds unless enabled
// - 128 Hz ticks converted to hundredths
// - module enable gates all counting, keeps contents
module rtcc_top
  import rtcc_pkg::*;
(
  input  wire logic                pclk,                       // system clock, 50 MHz
  input  wire logic                presetn,                    // async reset, active low
  input  wire logic                psel,                       // apb select
  input  wire logic                penable,                    // apb access phase
  input  wire logic                pwrite,                     // apb direction
  input  wire logic [`RTCC_AW-1:0] paddr,                      // apb byte address
  input  wire logic [31:0]         pwdata,                     // apb write data
  output logic                     pready,                     // apb ready
  output logic [31:0]              prdata,                     // apb read data
  output logic                     pslverr,                    // apb error, unmapped address
  input  wire logic                oscillator_reference_clock, // crystal clock, sampled
  output logic                     irq                         // combined interrupt request
);

  rtcc_flags_t       flags;
  rtcc_flags_t       irq_enable;
  rtcc_flags_t       arm;
  rtcc_flags_t       set_ev;
  rtcc_ctrl_t        ctrl;
  rtcc_tick_t        tick_kind;
  logic [7:0]        alarm_minute, alarm_hour;
  logic [7:0]        seconds_count, minutes_count, hours_count;
  logic [7:0]        day_of_month_count, month_count, year_offset_count, weekday_count;
  logic [7:0]        stopwatch_count;
  logic [7:0]        sub_tick, chr_raw, qcnt;
  logic [9:0]        pre_cnt, div;
  logic [7:0]        nticks, qticks, dmax;
  logic              osc_d, tick, sec_tick, min_inc, hr_inc, day_inc, mon_inc, yr_inc;
  logic              tb2_tick, tb1_tick, half_phase, chr_tick, match, match_d, alarm_set;
  logic              wr_done, rd_done, clr_req;
  logic [`RTCC_AW-1:0] acc_addr;
  logic [7:0]        wdat;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // year offset is two's complement; 2000 is a leap year and the range stays inside 1901..2099
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h0b: days_in = 8'h1e;
      `RTCC_FEB:                  days_in = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      default:                    days_in = 8'h1f;
    endcase
  endfunction

  function automatic logic [`RTCC_AW-1:0] clr_off(input int i);
    case (i)
      7:       clr_off = `RTCC_OFF_ALH;
      5:       clr_off = `RTCC_OFF_DAY;
      4:       clr_off = `RTCC_OFF_HR;
      3:       clr_off = `RTCC_OFF_MIN;
      2:       clr_off = `RTCC_OFF_SEC;
      default: clr_off = `RTCC_OFF_CHR;
    endcase
  endfunction

  function automatic logic mapped(input logic [`RTCC_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a >= `RTCC_OFF_IE) && (a <= `RTCC_OFF_CHR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, pready raised by the setup cycle

  assign acc_addr = paddr;
  assign wdat     = pwdata[7:0];
  assign wr_done  = psel && penable && pready && pwrite;
  assign rd_done  = psel && penable && pready && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(acc_addr);
    end
  end

  // read data is captured in the setup cycle so it stands still through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      case (acc_addr)
        `RTCC_OFF_IE:     prdata[7:0] <= irq_enable;
        `RTCC_OFF_STATUS: prdata[7:0] <= flags;
        `RTCC_OFF_CTRL:   prdata[7:0] <= {1'b0, ctrl.stopwatch_enable, ctrl.module_enable, 2'h0,
                                          ctrl.crystal_select};
        `RTCC_OFF_ALM:    prdata[7:0] <= alarm_minute;
        `RTCC_OFF_ALH:    prdata[7:0] <= alarm_hour;
        `RTCC_OFF_SEC:    prdata[7:0] <= seconds_count;
        `RTCC_OFF_MIN:    prdata[7:0] <= minutes_count;
        `RTCC_OFF_HR:     prdata[7:0] <= hours_count;
        `RTCC_OFF_DAY:    prdata[7:0] <= day_of_month_count;
        `RTCC_OFF_MON:    prdata[7:0] <= month_count;
        `RTCC_OFF_YR:     prdata[7:0] <= year_offset_count;
        `RTCC_OFF_DOW:    prdata[7:0] <= weekday_count;
        `RTCC_OFF_CHR:    prdata[7:0] <= stopwatch_count;
        default:          prdata[7:0] <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and alarm registers

  assign clr_req = wr_done && (acc_addr == `RTCC_OFF_CTRL) && wdat[`RTCC_CB_CLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= '0;
      irq_enable <= '0;
    end else if (wr_done) begin
      if (acc_addr == `RTCC_OFF_IE)
        irq_enable <= wdat;
      if (acc_addr == `RTCC_OFF_CTRL) begin
        ctrl.stopwatch_enable <= wdat[`RTCC_CB_SWEN];
        ctrl.module_enable    <= wdat[`RTCC_CB_MODEN];
        ctrl.select_locked    <= 1'b1;
        if (!ctrl.select_locked)
          ctrl.crystal_select <= wdat[2:0];
      end
    end
  end

  // alarm registers store anything; out-of-range values just never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_minute <= `RTCC_RST_TIME;
      alarm_hour   <= `RTCC_RST_TIME;
    end else if (wr_done) begin
      if (acc_addr == `RTCC_OFF_ALM)
        alarm_minute <= wdat;
      if (acc_addr == `RTCC_OFF_ALH)
        alarm_hour <= wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: code 001 is reserved and runs as the 32.768 kHz setting

  always_comb begin
    case (ctrl.crystal_select)
      3'b010:         div = `RTCC_DIV_32000;
      3'b011:         div = `RTCC_DIV_38400;
      3'b100, 3'b110: div = `RTCC_DIV_64000;
      3'b101, 3'b111: div = `RTCC_DIV_76800;
      default:        div = `RTCC_DIV_32768;
    endcase
    tick_kind = (ctrl.crystal_select[2:1] == 2'b00) ? RTCC_TICK_128HZ : RTCC_TICK_100HZ;
    nticks    = (tick_kind == RTCC_TICK_128HZ) ? 8'(`RTCC_TICKS(`RTCC_HZ_128))
                                               : 8'(`RTCC_TICKS(`RTCC_HZ_100));
    qticks    = (tick_kind == RTCC_TICK_128HZ) ? 8'(`RTCC_QTICKS(`RTCC_HZ_128))
                                               : 8'(`RTCC_QTICKS(`RTCC_HZ_100));
  end

  assign tick = ctrl.module_enable && oscillator_reference_clock && !osc_d
                && (pre_cnt == div - 10'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d   <= 1'b0;
      pre_cnt <= 10'h000;
    end else begin
      osc_d <= oscillator_reference_clock;
      if (ctrl.module_enable && oscillator_reference_clock && !osc_d)
        pre_cnt <= tick ? 10'h000 : pre_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second and timebase divider; four quarters always make one second

  assign sec_tick = tick && (sub_tick == nticks - 8'h01);
  assign tb2_tick = tick && (qcnt == qticks - 8'h01);
  assign tb1_tick = tb2_tick && half_phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_tick   <= 8'h00;
      qcnt       <= 8'h00;
      half_phase <= 1'b0;
    end else if (tick) begin
      sub_tick <= sec_tick ? 8'h00 : sub_tick + 8'h01;
      qcnt     <= tb2_tick ? 8'h00 : qcnt + 8'h01;
      if (tb2_tick)
        half_phase <= !half_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stopwatch: raw count in tick units, stored as hundredths

  assign chr_tick = tick && ctrl.stopwatch_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chr_raw <= 8'h00;
    end else if (clr_req) begin
      chr_raw <= 8'h00;
    end else if (chr_tick) begin
      chr_raw <= (chr_raw >= nticks - 8'h01) ? 8'h00 : chr_raw + 8'h01;
    end
  end

  // 128 Hz raw count times 100/128 lands on 0..99, so the wrap after 99 holds for both rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopwatch_count <= 8'h00;
    end else if (tick_kind == RTCC_TICK_128HZ) begin
      stopwatch_count <= 8'(({4'h0, chr_raw} * 12'd25) >> 5);
    end else begin
      stopwatch_count <= chr_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time counters: a valid write wins over a tick in the same cycle

  assign dmax    = days_in(month_count, year_offset_count);
  assign min_inc = sec_tick && (seconds_count == `RTCC_SEC_MAX);
  assign hr_inc  = min_inc && (minutes_count == `RTCC_SEC_MAX);
  assign day_inc = hr_inc && (hours_count == `RTCC_HR_MAX);
  assign mon_inc = day_inc && (day_of_month_count >= dmax);
  assign yr_inc  = mon_inc && (month_count == `RTCC_MON_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seconds_count <= `RTCC_RST_TIME;
      minutes_count <= `RTCC_RST_TIME;
      hours_count   <= `RTCC_RST_TIME;
    end else begin
      if (wr_done && acc_addr == `RTCC_OFF_SEC && in_range(wdat, 8'h00, `RTCC_SEC_MAX))
        seconds_count <= wdat;
      else if (sec_tick)
        seconds_count <= min_inc ? 8'h00 : seconds_count + 8'h01;
      if (wr_done && acc_addr == `RTCC_OFF_MIN && in_range(wdat, 8'h00, `RTCC_SEC_MAX))
        minutes_count <= wdat;
      else if (min_inc)
        minutes_count <= hr_inc ? 8'h00 : minutes_count + 8'h01;
      if (wr_done && acc_addr == `RTCC_OFF_HR && in_range(wdat, 8'h00, `RTCC_HR_MAX))
        hours_count <= wdat;
      else if (hr_inc)
        hours_count <= day_inc ? 8'h00 : hours_count + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      day_of_month_count <= `RTCC_RST_DATE;
      month_count        <= `RTCC_RST_DATE;
      year_offset_count  <= `RTCC_RST_TIME;
      weekday_count      <= `RTCC_RST_TIME;
    end else begin
      if (wr_done && acc_addr == `RTCC_OFF_DAY && in_range(wdat, `RTCC_DAY_MIN, dmax))
        day_of_month_count <= wdat;
      else if (day_inc)
        day_of_month_count <= mon_inc ? `RTCC_DAY_MIN : day_of_month_count + 8'h01;
      if (wr_done && acc_addr == `RTCC_OFF_MON && in_range(wdat, 8'h01, `RTCC_MON_MAX))
        month_count <= wdat;
      else if (mon_inc)
        month_count <= yr_inc ? 8'h01 : month_count + 8'h01;
      // past +99 the year runs round to -99 rather than leaving the valid range
      if (wr_done && acc_addr == `RTCC_OFF_YR && $signed(wdat) >= $signed(`RTCC_YR_MIN)
          && $signed(wdat) <= $signed(`RTCC_YR_MAX))
        year_offset_count <= wdat;
      else if (yr_inc)
        year_offset_count <= (year_offset_count == `RTCC_YR_MAX) ? `RTCC_YR_MIN
                                                                 : year_offset_count + 8'h01;
      if (wr_done && acc_addr == `RTCC_OFF_DOW && in_range(wdat, 8'h00, `RTCC_DOW_MAX))
        weekday_count <= wdat;
      else if (day_inc)
        weekday_count <= (weekday_count == `RTCC_DOW_MAX) ? 8'h00 : weekday_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm match: flagged on entry into the match, so a clear is not undone at once

  assign match = in_range(alarm_minute, 8'h00, `RTCC_SEC_MAX) && in_range(alarm_hour, 8'h00, `RTCC_HR_MAX)
                 && (alarm_minute == minutes_count) && (alarm_hour == hours_count);
  assign alarm_set = match && !match_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      match_d <= 1'b0;
    else
      match_d <= match;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: a status read arms the flags it showed, the matching register read clears them

  assign set_ev = '{alarm: alarm_set, stopwatch: chr_tick, day: day_inc, hour: hr_inc,
                    minute: min_inc, second: sec_tick, half_second: tb1_tick, quarter_second: tb2_tick};

  generate
    for (genvar i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags[i] <= 1'b0;
          arm[i]   <= 1'b0;
        end else begin
          if (rd_done && acc_addr == `RTCC_OFF_STATUS)
            arm[i] <= prdata[i];
          else if (rd_done && acc_addr == clr_off(i))
            arm[i] <= 1'b0;
          // set wins over clear
          if (set_ev[i])
            flags[i] <= 1'b1;
          else if (rd_done && acc_addr == clr_off(i) && arm[i])
            flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flags & irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_status_rd_alarm;
    rd_done && acc_addr == `RTCC_OFF_STATUS && prdata[7];
  endsequence

  sequence s_alh_rd_quiet;
    rd_done && acc_addr == `RTCC_OFF_ALH && !alarm_set;
  endsequence

  AST_ALM_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_rd_alarm ##[2:3] s_alh_rd_quiet |=> !flags.alarm)
    else $error("alarm flag not cleared by status then alarm hour read");

  AST_SELECT_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.select_locked |=> $stable(ctrl.crystal_select))
    else $error("crystal select changed after first write");

  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(flags) & $past(irq_enable)))
    else $error("irq does not follow enabled flags");

  AST_ALM_SET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(match) |=> flags.alarm)
    else $error("alarm flag missed on match");

  AST_SEC_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    sec_tick && seconds_count == `RTCC_SEC_MAX && !wr_done |=> seconds_count == 8'h00 && flags.minute)
    else $error("seconds did not wrap into minutes");

  AST_SEC_BADWR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && acc_addr == `RTCC_OFF_SEC && wdat > `RTCC_SEC_MAX && !sec_tick |=> $stable(seconds_count))
    else $error("invalid seconds write took effect");

  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.module_enable && !wr_done |=> $stable({seconds_count, minutes_count, hours_count, chr_raw}))
    else $error("counting while module disabled");

  AST_CHR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    clr_req |=> chr_raw == 8'h00 ##1 stopwatch_count == 8'h00)
    else $error("stopwatch not cleared");

  AST_CHR_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    stopwatch_count <= `RTCC_CHR_MAX)
    else $error("stopwatch count above 99");

endmodule

// ===== rtcc_map.svh
// register offsets, field positions, reset values and timing counts of the rtc block
// assumes a 12-bit apb byte address and byte-addressed 32-bit aligned words
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH
`define RTCC_AW           12
`define RTCC_OFF_IE       12'h040
`define RTCC_OFF_STATUS   12'h044
`define RTCC_OFF_CTRL     12'h048
`define RTCC_OFF_ALM      12'h04c
`define RTCC_OFF_ALH      12'h050
`define RTCC_OFF_SEC      12'h054
`define RTCC_OFF_MIN      12'h058
`define RTCC_OFF_HR       12'h05c
`define RTCC_OFF_DAY      12'h060
`define RTCC_OFF_MON      12'h064
`define RTCC_OFF_YR       12'h068
`define RTCC_OFF_DOW      12'h06c
`define RTCC_OFF_CHR      12'h070
// control register fields
`define RTCC_CB_CLR       7
`define RTCC_CB_SWEN      6
`define RTCC_CB_MODEN     5
// oscillator cycles per counter tick, one per crystal choice
`define RTCC_DIV_32768    10'h100
`define RTCC_DIV_32000    10'h140
`define RTCC_DIV_38400    10'h180
`define RTCC_DIV_64000    10'h280
`define RTCC_DIV_76800    10'h300
// tick rates and timebase periods
`define RTCC_HZ_128       128
`define RTCC_HZ_100       100
`define RTCC_TB2_MS       250
`define RTCC_CHR_STEP_MS  10
`define RTCC_TICKS(hz)    (((hz) * `RTCC_CHR_STEP_MS * 100) / 1000)
`define RTCC_QTICKS(hz)   (((hz) * `RTCC_TB2_MS) / 1000)
// counter limits
`define RTCC_SEC_MAX      8'h3b
`define RTCC_HR_MAX       8'h17
`define RTCC_MON_MAX      8'h0c
`define RTCC_DOW_MAX      8'h06
`define RTCC_DAY_MIN      8'h01
`define RTCC_YR_MIN       8'h9d
`define RTCC_YR_MAX       8'h63
`define RTCC_CHR_MAX      8'h63
`define RTCC_FEB          8'h02
// reset values of the time counters
`define RTCC_RST_TIME     8'h00
`define RTCC_RST_DATE     8'h01
`endif

// ===== rtcc_pkg.sv
// types shared by the rtc block
// assumes rtcc_map.svh supplies every number
package rtcc_pkg;
  typedef struct packed {
    logic alarm;
    logic stopwatch;
    logic day;
    logic hour;
    logic minute;
    logic second;
    logic half_second;
    logic quarter_second;
  } rtcc_flags_t;

  typedef struct packed {
    logic       stopwatch_enable;
    logic       module_enable;
    logic       select_locked;
    logic [2:0] crystal_select;
  } rtcc_ctrl_t;

  typedef enum logic {RTCC_TICK_128HZ, RTCC_TICK_100HZ} rtcc_tick_t;
endpackage

// ===== rtcc_top_tb_top.sv
// self-checking bench for the rtc block: apb master tasks, one task per scenario
// assumes rtcc_top and rtcc_map.svh of the design, pclk 50 MHz, oscillator sampled on pclk
`timescale 1ns/1ps
`include "rtcc_map.svh"
module rtcc_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, osc, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, a;
  int          err_count, n_tests;
  int          cyc = 0;

  rtcc_top i_rtcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .oscillator_reference_clock(osc), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // oscillator toggles every 2 pclk, half the fastest rate the sampler accepts (a toggle every pclk)
  initial begin
    osc = 1'b0;
    forever begin
      repeat (2) @(posedge pclk);
      osc <= ~osc;
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      finish_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(r, exp);
  endtask
  task automatic wt(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
  endtask
  task automatic wait_irq(input logic v, input int lim);
    int n = 0;
    while (irq !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(`RTCC_OFF_CTRL, 32'h0);
    rd(`RTCC_OFF_DAY, 32'h1);
    rd(`RTCC_OFF_MON, 32'h1);
    wt(`RTCC_OFF_CHR, 8'h55);
    rd(`RTCC_OFF_CHR, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({r[31:1], e}, 32'h1);
  endtask
  // month goes before day so that day 31 is legal
  task automatic t_limits;
    logic [11:0] ad [7] = '{`RTCC_OFF_SEC, `RTCC_OFF_MIN, `RTCC_OFF_HR, `RTCC_OFF_MON, `RTCC_OFF_DAY,
                            `RTCC_OFF_YR, `RTCC_OFF_DOW};
    logic [7:0]  gd [7] = '{8'h3b, 8'h3b, 8'h17, 8'h0c, 8'h1f, 8'h9d, 8'h06};
    logic [7:0]  bd [7] = '{8'h3c, 8'h3c, 8'h18, 8'h0d, 8'h20, 8'h9c, 8'h07};
    for (int i = 0; i < 7; i++) begin
      wt(ad[i], gd[i]);
      wt(ad[i], bd[i]);
      rd(ad[i], {24'h0, gd[i]});
    end
    wt(`RTCC_OFF_MON, 8'h02);
    wt(`RTCC_OFF_YR, 8'h01);
    wt(`RTCC_OFF_DAY, 8'h1d);
    rd(`RTCC_OFF_DAY, 32'h1f);
    wt(`RTCC_OFF_YR, 8'h04);
    wt(`RTCC_OFF_DAY, 8'h1d);
    rd(`RTCC_OFF_DAY, 32'h1d);
  endtask
  task automatic t_crystal;
    wt(`RTCC_OFF_CTRL, 8'h02);
    wt(`RTCC_OFF_CTRL, 8'h05);
    rd(`RTCC_OFF_CTRL, 32'h02);
    repeat (3000) @(posedge pclk);
    // 0:00 after reset matches the reset alarm, so only the alarm flag may be up
    rd(`RTCC_OFF_STATUS, 32'h80);
  endtask
  task automatic t_stopwatch;
    wt(`RTCC_OFF_IE, 8'h40);
    wt(`RTCC_OFF_CTRL, 8'h62);
    wait_irq(1'b1, 3000);
    chk(irq, 1);
    apb(1'b0, `RTCC_OFF_STATUS, 32'h0);
    chk(r[6], 1);
    apb(1'b0, `RTCC_OFF_CHR, 32'h0);
    chk(r[7:0] != 8'h00, 1);
    wt(`RTCC_OFF_CTRL, 8'h22);
    apb(1'b0, `RTCC_OFF_STATUS, 32'h0);
    apb(1'b0, `RTCC_OFF_CHR, 32'h0);
    a = r;
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    repeat (3000) @(posedge pclk);
    rd(`RTCC_OFF_CHR, a);
    wt(`RTCC_OFF_CTRL, 8'ha2);
    rd(`RTCC_OFF_CHR, 32'h0);
    rd(`RTCC_OFF_CTRL, 32'h22);
    wt(`RTCC_OFF_IE, 8'h01);
    wait_irq(1'b1, 40000);
    apb(1'b0, `RTCC_OFF_STATUS, 32'h0);
    chk(r[0], 1);
    apb(1'b0, `RTCC_OFF_CHR, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
  endtask
  // an invalid alarm minute first, so any earlier match is flushed
  task automatic t_alarm;
    wt(`RTCC_OFF_ALM, 8'h3c);
    wt(`RTCC_OFF_IE, 8'h80);
    apb(1'b0, `RTCC_OFF_STATUS, 32'h0);
    apb(1'b0, `RTCC_OFF_ALH, 32'h0);
    wt(`RTCC_OFF_HR, 8'h05);
    wt(`RTCC_OFF_MIN, 8'h0a);
    wt(`RTCC_OFF_ALH, 8'h05);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    wt(`RTCC_OFF_ALM, 8'h0a);
    wait_irq(1'b1, 10);
    chk(irq, 1);
    apb(1'b0, `RTCC_OFF_ALH, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    apb(1'b0, `RTCC_OFF_STATUS, 32'h0);
    chk(r[7], 1);
    apb(1'b0, `RTCC_OFF_ALH, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    presetn = 1'b0; err_count = 0; n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_limits;
    t_crystal;
    t_stopwatch;
    t_alarm;
    finish_test;
  end
endmodule
